// ### rtl/uer_regs.sv
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - bit 7 flags bit stuffing violation
// - bit 5 flags byte count overrun, truncate
// - bit 4 flags turnaround time-out
// - bit 3 flags non-integral data field
// - bit 2 flags data CRC16 failure
// - device role: bad token CRC rejected, bit 1
// - host role: bit 1 is end-of-frame error
// - bit 0 flags PID check failure
// - write one clears flag; 15:8 read zero
// - per-flag enable bits, reset zero
// - enable bit 1 follows current role
// - summary flag is OR of enabled flags
// - sixteen endpoint registers, upper byte zero
// - bit 4 blocks SETUP only when bidirectional
// - bit 3 enables rx, bit 2 tx
// - bit 1 shows endpoint stalled
// - bit 0 enables handshakes
// - ep0 bit 7 host low-speed direct
// - ep0 bit 6 disables NAK retry
// - bits 7:6 only ep0, host role
// - pwm disabled holds idle level
// - bit 9 selects active-low output
// - bit 8 runs counter independently
module uer_regs #(
    parameter int PWM_CNT_W = 8
) (
    input  wire logic                        CLK_I,
    input  wire logic                        RESET_I,
    input  wire logic                        CE_I,
    input  wire logic [uer_pkg::ADDR_W-1:0]  ADDR_I,
    input  wire logic [uer_pkg::DATA_W-1:0]  WDATA_I,
    input  wire logic                        WR_I,
    input  wire logic                        RD_I,
    output logic      [uer_pkg::DATA_W-1:0]  RDATA_O,
    input  wire logic                        HOST_ROLE_I,
    input  wire logic                        BIT_STUFF_ERR_I,
    input  wire logic                        BUFFER_OVERRUN_ERR_I,
    input  wire logic                        TURNAROUND_TIMEOUT_I,
    input  wire logic                        PARTIAL_BYTE_ERR_I,
    input  wire logic                        DATA_CRC_FAIL_I,
    input  wire logic                        TOKEN_CRC_FAIL_I,
    input  wire logic                        END_OF_FRAME_ERR_I,
    input  wire logic                        PID_CHECK_FAIL_I,
    input  wire logic [3:0]                  RX_EP_I,
    input  wire logic                        EP_STALL_SET_I,
    input  wire logic [3:0]                  EP_STALL_EP_I,
    output logic                             TOKEN_REJECT_O,
    output logic                             RX_TRUNCATE_O,
    output logic                             ERROR_SUMMARY_IRQ_FLAG_O,
    output logic      [uer_pkg::NUM_EP-1:0]  ENDPOINT_RX_EN_O,
    output logic      [uer_pkg::NUM_EP-1:0]  ENDPOINT_TX_EN_O,
    output logic      [uer_pkg::NUM_EP-1:0]  SETUP_ALLOWED_O,
    output logic      [uer_pkg::NUM_EP-1:0]  ENDPOINT_HANDSHAKE_EN_O,
    output logic      [uer_pkg::NUM_EP-1:0]  ENDPOINT_STALLED_O,
    output logic                             LOW_SPEED_DIRECT_O,
    output logic                             NAK_RETRY_DISABLE_O,
    output logic                             VBUS_PWM_O,
    output logic      [PWM_CNT_W-1:0]        VBUS_PWM_COUNT_O
);
    import uer_pkg::*;

    logic [7:0]          err_flags_reg;
    logic [7:0]          err_en_reg;
    logic [7:0]          err_event;
    logic [7:0]          ep_reg [NUM_EP];
    logic [15:0]         pwm_ctrl_reg;
    logic [PWM_CNT_W-1:0] pwm_cnt_reg;
    logic                pwm_out_reg;
    logic                host_s1_reg;
    logic                host_reg;
    logic [DATA_W-1:0]   rdata_next;
    logic                summary;
    logic                wr_flags;
    logic                wr_en;
    logic                wr_pwm;
    logic                ep_sel;
    logic [3:0]          ep_idx;

    // error events arrive from the serial engine on the same clock
    always_comb begin
        err_event                 = 8'h00;
        err_event[BIT_STUFF]      = BIT_STUFF_ERR_I;
        err_event[BIT_OVERRUN]    = BUFFER_OVERRUN_ERR_I;
        err_event[BIT_TURNAROUND] = TURNAROUND_TIMEOUT_I;
        err_event[BIT_PARTIAL]    = PARTIAL_BYTE_ERR_I;
        err_event[BIT_CRC16]      = DATA_CRC_FAIL_I;
        // one flag bit shared by both roles, chosen by role
        err_event[BIT_CRC5_EOF]   = host_reg ? END_OF_FRAME_ERR_I
                                             : TOKEN_CRC_FAIL_I;
        err_event[BIT_PID]        = PID_CHECK_FAIL_I;
    end

    // role pin may be a strap from another domain
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            host_s1_reg <= 1'b0;
            host_reg    <= 1'b0;
        end else if (CE_I) begin
            host_s1_reg <= HOST_ROLE_I;
            host_reg    <= host_s1_reg;
        end
    end

    assign wr_flags = WR_I && (ADDR_I == OFS_ERR_FLAGS);
    assign wr_en    = WR_I && (ADDR_I == OFS_ERR_EN);
    assign wr_pwm   = WR_I && (ADDR_I == OFS_PWM_CTRL);
    assign ep_sel   = (ADDR_I[4] == OFS_EP_BASE[4]);
    assign ep_idx   = ADDR_I[3:0];

    // combinational reject/truncate pulses go straight back to the engine
    assign TOKEN_REJECT_O = !host_reg && TOKEN_CRC_FAIL_I;
    assign RX_TRUNCATE_O  = BUFFER_OVERRUN_ERR_I;

    // whole-word write clears ones; a new event wins the cycle
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            err_flags_reg <= RST_BYTE;
        end else if (CE_I) begin
            err_flags_reg <= ((err_flags_reg
                              & ~(wr_flags ? WDATA_I[7:0] : 8'h00))
                              | err_event) & ERR_IMPL_MASK;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            err_en_reg <= RST_BYTE;
        end else if (CE_I && wr_en) begin
            err_en_reg <= WDATA_I[7:0] & ERR_IMPL_MASK;
        end
    end

    // bit 1 enable is role-agnostic storage: it gates whichever
    // error currently owns flag bit 1
    assign summary = |(err_flags_reg & err_en_reg);

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ERROR_SUMMARY_IRQ_FLAG_O <= 1'b0;
        end else if (CE_I) begin
            ERROR_SUMMARY_IRQ_FLAG_O <= summary;
        end
    end

    // endpoint control registers, one per endpoint number
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            localparam logic [7:0] MASK =
                (g == 0) ? (EP_IMPL_MASK | EP0_HOST_MASK) : EP_IMPL_MASK;
            always_ff @(posedge CLK_I) begin
                if (RESET_I) begin
                    ep_reg[g] <= RST_BYTE;
                end else if (CE_I) begin
                    if (WR_I && ep_sel && ep_idx == 4'(g)) begin
                        ep_reg[g] <= WDATA_I[7:0] & MASK;
                    end
                    // stall report from the engine beats a software write
                    if (EP_STALL_SET_I && EP_STALL_EP_I == 4'(g)) begin
                        ep_reg[g][EP_STALL] <= 1'b1;
                    end
                end
            end
            always_ff @(posedge CLK_I) begin
                if (RESET_I) begin
                    ENDPOINT_RX_EN_O[g]        <= 1'b0;
                    ENDPOINT_TX_EN_O[g]        <= 1'b0;
                    SETUP_ALLOWED_O[g]         <= 1'b0;
                    ENDPOINT_HANDSHAKE_EN_O[g] <= 1'b0;
                    ENDPOINT_STALLED_O[g]      <= 1'b0;
                end else if (CE_I) begin
                    ENDPOINT_RX_EN_O[g] <= ep_reg[g][EP_RX];
                    ENDPOINT_TX_EN_O[g] <= ep_reg[g][EP_TX];
                    // setup only meaningful on a bidirectional endpoint
                    SETUP_ALLOWED_O[g]  <= ep_reg[g][EP_RX]
                                        && ep_reg[g][EP_TX]
                                        && !ep_reg[g][EP_SETUP_BLK];
                    ENDPOINT_HANDSHAKE_EN_O[g] <= ep_reg[g][EP_HSHK];
                    ENDPOINT_STALLED_O[g]      <= ep_reg[g][EP_STALL];
                end
            end
        end
    endgenerate

    // host-only options; they stay stored but act only in host role
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            LOW_SPEED_DIRECT_O  <= 1'b0;
            NAK_RETRY_DISABLE_O <= 1'b0;
        end else if (CE_I) begin
            LOW_SPEED_DIRECT_O  <= host_reg && ep_reg[0][EP_LOW_SPEED];
            NAK_RETRY_DISABLE_O <= host_reg && ep_reg[0][EP_RETRY_DIS];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            pwm_ctrl_reg <= RST_WORD;
        end else if (CE_I && wr_pwm) begin
            pwm_ctrl_reg <= WDATA_I & PWM_IMPL_MASK;
        end
    end

    // free-running counter; period/duty compare lives elsewhere
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            pwm_cnt_reg <= '0;
        end else if (CE_I && pwm_ctrl_reg[PWM_CNT_BIT]) begin
            pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
        end
    end

    // active phase is the upper half of the count as a stand-in
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            pwm_out_reg <= 1'b0;
        end else if (CE_I) begin
            if (!pwm_ctrl_reg[PWM_ON_BIT]) begin
                pwm_out_reg <= pwm_ctrl_reg[PWM_POL_BIT];
            end else begin
                pwm_out_reg <= pwm_cnt_reg[PWM_CNT_W-1]
                             ^ pwm_ctrl_reg[PWM_POL_BIT];
            end
        end
    end
    assign VBUS_PWM_O       = pwm_out_reg;
    assign VBUS_PWM_COUNT_O = pwm_cnt_reg;

    // read mux; ep bits 7:6 hidden unless host role
    always_comb begin
        rdata_next = '0;
        if (ep_sel) begin
            rdata_next[7:0] = ep_reg[ep_idx]
                & ((ep_idx == 4'h0 && host_reg)
                   ? (EP_IMPL_MASK | EP0_HOST_MASK) : EP_IMPL_MASK);
        end else begin
            unique case (ADDR_I)
                OFS_ERR_FLAGS: rdata_next[7:0] = err_flags_reg;
                OFS_ERR_EN:    rdata_next[7:0] = err_en_reg;
                OFS_PWM_CTRL:  rdata_next      = pwm_ctrl_reg;
                OFS_MAIN_STAT: rdata_next[MAIN_ERR_BIT] = summary;
                default:       rdata_next      = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            RDATA_O <= RST_WORD;
        end else if (CE_I) begin
            RDATA_O <= RD_I ? rdata_next : RST_WORD;
        end
    end
endmodule

// ### rtl/uer_pkg.sv
package uer_pkg;
    // register word indices on the plain port
    localparam int        ADDR_W          = 5;
    localparam logic [4:0] OFS_ERR_FLAGS  = 5'h00;
    localparam logic [4:0] OFS_ERR_EN     = 5'h01;
    localparam logic [4:0] OFS_PWM_CTRL   = 5'h02;
    localparam logic [4:0] OFS_MAIN_STAT  = 5'h03;
    localparam logic [4:0] OFS_EP_BASE    = 5'h10;
    localparam int        DATA_W          = 16;
    localparam int        NUM_EP          = 16;
    // error flag positions
    localparam int        BIT_PID         = 0;
    localparam int        BIT_CRC5_EOF    = 1;
    localparam int        BIT_CRC16       = 2;
    localparam int        BIT_PARTIAL     = 3;
    localparam int        BIT_TURNAROUND  = 4;
    localparam int        BIT_OVERRUN     = 5;
    localparam int        BIT_STUFF       = 7;
    localparam logic [7:0] ERR_IMPL_MASK  = 8'hbf;
    // endpoint control fields
    localparam int        EP_HSHK         = 0;
    localparam int        EP_STALL        = 1;
    localparam int        EP_TX           = 2;
    localparam int        EP_RX           = 3;
    localparam int        EP_SETUP_BLK    = 4;
    localparam int        EP_RETRY_DIS    = 6;
    localparam int        EP_LOW_SPEED    = 7;
    localparam logic [7:0] EP_IMPL_MASK   = 8'h1f;
    localparam logic [7:0] EP0_HOST_MASK  = 8'hc0;
    // pwm control fields
    localparam int        PWM_CNT_BIT     = 8;
    localparam int        PWM_POL_BIT     = 9;
    localparam int        PWM_ON_BIT      = 15;
    localparam logic [15:0] PWM_IMPL_MASK = 16'h8300;
    // main status: summary error bit
    localparam int        MAIN_ERR_BIT    = 1;
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [15:0] RST_WORD      = 16'h0000;
endpackage

// ### bench/uer_properties.sv
`timescale 1ns/1ps
module uer_chk
    import uer_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        RESET_I,
    input wire logic        CE_I,
    input wire logic [4:0]  ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [15:0] RDATA_O,
    input wire logic        HOST_ROLE_I,
    input wire logic        BUFFER_OVERRUN_ERR_I,
    input wire logic        TOKEN_CRC_FAIL_I,
    input wire logic        EP_STALL_SET_I,
    input wire logic [3:0]  EP_STALL_EP_I,
    input wire logic        TOKEN_REJECT_O,
    input wire logic        RX_TRUNCATE_O,
    input wire logic        ERROR_SUMMARY_IRQ_FLAG_O,
    input wire logic [15:0] ENDPOINT_RX_EN_O,
    input wire logic [15:0] ENDPOINT_TX_EN_O,
    input wire logic [15:0] SETUP_ALLOWED_O,
    input wire logic [15:0] ENDPOINT_HANDSHAKE_EN_O,
    input wire logic [15:0] ENDPOINT_STALLED_O,
    input wire logic        LOW_SPEED_DIRECT_O,
    input wire logic        NAK_RETRY_DISABLE_O,
    input wire logic        VBUS_PWM_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    logic       ew;
    logic [3:0] wn;
    assign ew = CE_I && WR_I && ADDR_I[4];
    assign wn = ADDR_I[3:0];
    trunc_copy_a: assert property (
        RX_TRUNCATE_O == BUFFER_OVERRUN_ERR_I) else $error("truncate wrong");
    token_reject_a: assert property (
        !HOST_ROLE_I [*4] ##0 TOKEN_CRC_FAIL_I |-> TOKEN_REJECT_O)
        else $error("bad token not rejected");
    host_only_a: assert property (
        !HOST_ROLE_I [*4] |-> !LOW_SPEED_DIRECT_O && !NAK_RETRY_DISABLE_O)
        else $error("ep0 host bits active in device role");
    pwm_idle_a: assert property (
        CE_I && WR_I && ADDR_I == OFS_PWM_CTRL && !WDATA_I[PWM_ON_BIT]
        |-> ##2 VBUS_PWM_O == $past(WDATA_I[PWM_POL_BIT], 2))
        else $error("pwm idle level wrong");
    ep_dir_a: assert property (ew |-> ##2
        ENDPOINT_RX_EN_O[$past(wn, 2)] == $past(WDATA_I[EP_RX], 2) &&
        ENDPOINT_TX_EN_O[$past(wn, 2)] == $past(WDATA_I[EP_TX], 2))
        else $error("endpoint direction wrong");
    ep_hshk_a: assert property (ew |-> ##2
        ENDPOINT_HANDSHAKE_EN_O[$past(wn, 2)] == $past(WDATA_I[EP_HSHK], 2))
        else $error("handshake enable wrong");
    ep_setup_a: assert property (
        ew && WDATA_I[EP_RX] && WDATA_I[EP_TX] |-> ##2
        SETUP_ALLOWED_O[$past(wn, 2)] == !$past(WDATA_I[EP_SETUP_BLK], 2))
        else $error("setup permission wrong");
    stall_set_a: assert property (
        CE_I && EP_STALL_SET_I |-> ##2 ENDPOINT_STALLED_O[$past(EP_STALL_EP_I, 2)])
        else $error("stall not shown");
    upper_zero_a: assert property (
        CE_I && RD_I && ADDR_I != OFS_PWM_CTRL |=> RDATA_O[15:8] == 8'h00)
        else $error("upper byte not zero");
    ep_write_c: cover property (ew);
    stall_c: cover property (EP_STALL_SET_I);
    summary_c: cover property ($rose(ERROR_SUMMARY_IRQ_FLAG_O));
endmodule

// ### bench/uer_usb_side.sv
`timescale 1ns/1ps
module uer_usb_side (
    input  wire logic       clk_i,
    input  wire logic       fire_i,
    input  wire logic [3:0] kind_i,
    input  wire logic [3:0] ep_i,
    output logic      [7:0] err_o,
    output logic            stall_o,
    output logic      [3:0] stall_ep_o
);
    // one-cycle pulses; kind 8 reports a stall, idle stall number is noise
    always @(posedge clk_i) begin
        err_o <= (fire_i && !kind_i[3]) ? 8'h01 << kind_i[2:0] : 8'h00;
        stall_o <= fire_i && kind_i[3];
        stall_ep_o <= fire_i ? ep_i : ~ep_i;
    end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import uer_pkg::*;
    logic        clk, rst, wr_s, rd_s, host, fire, st, sum, ls, nr, pwm;
    logic [4:0]  addr;
    logic [3:0]  kind, ep, st_ep;
    logic [7:0]  ev, cnt;
    logic [15:0] wdata, rdata, rx, tx, su, hs, sl, exp, c0;
    logic [15:0] e_rx, e_tx, e_su, e_hs, e_st;
    int          n_fail, checks;
    uer_regs #(.PWM_CNT_W(8)) uer_regs_inst (.CLK_I(clk), .RESET_I(rst),
        .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdata), .HOST_ROLE_I(host),
        .BIT_STUFF_ERR_I(ev[7]), .BUFFER_OVERRUN_ERR_I(ev[5]),
        .TURNAROUND_TIMEOUT_I(ev[4]), .PARTIAL_BYTE_ERR_I(ev[3]),
        .DATA_CRC_FAIL_I(ev[2]), .TOKEN_CRC_FAIL_I(ev[1]),
        .END_OF_FRAME_ERR_I(ev[6]), .PID_CHECK_FAIL_I(ev[0]),
        .RX_EP_I(4'h0), .EP_STALL_SET_I(st), .EP_STALL_EP_I(st_ep),
        .TOKEN_REJECT_O(), .RX_TRUNCATE_O(), .ERROR_SUMMARY_IRQ_FLAG_O(sum),
        .ENDPOINT_RX_EN_O(rx), .ENDPOINT_TX_EN_O(tx), .SETUP_ALLOWED_O(su),
        .ENDPOINT_HANDSHAKE_EN_O(hs), .ENDPOINT_STALLED_O(sl),
        .LOW_SPEED_DIRECT_O(ls), .NAK_RETRY_DISABLE_O(nr),
        .VBUS_PWM_O(pwm), .VBUS_PWM_COUNT_O(cnt));
    uer_usb_side uer_usb_side_inst (.clk_i(clk), .fire_i(fire),
        .kind_i(kind), .ep_i(ep), .err_o(ev), .stall_o(st), .stall_ep_o(st_ep));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] seen, e);
        checks++;
        if (seen !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    // data stands only in the cycle after the strobe, so sample just then
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk("read data", rdata, e);
        @(posedge clk);
    endtask
    task automatic fire_ev(input logic [3:0] k, input logic [3:0] e);
        kind <= k;
        ep <= e;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        rst = 1'b1; wr_s = 1'b0; rd_s = 1'b0; host = 1'b0; fire = 1'b0;
        addr = 5'h00; wdata = 16'h0000; kind = 4'h0; ep = 4'h0;
        n_fail = 0; checks = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        wr(5'h05, 16'hffff);
        for (int a = 0; a < 32; a++)
            rd(a[4:0], 16'h0000);
        wr(OFS_ERR_EN, 16'hffff);
        rd(OFS_ERR_EN, 16'h00bf);
        wr(OFS_ERR_EN, 16'h0000);
        exp = 16'h0000;
        for (int k = 0; k < 8; k++) begin
            if (k != 6) begin
                fire_ev(k[3:0], 4'h0);
                @(posedge clk);
                exp[k] = 1'b1;
                rd(OFS_ERR_FLAGS, exp);
            end
        end
        chk("summary", {15'h0, sum}, 16'h0000);
        wr(OFS_ERR_FLAGS, 16'h0007);
        rd(OFS_ERR_FLAGS, 16'h00b8);
        wr(OFS_ERR_FLAGS, 16'h0000);
        fire_ev(4'h6, 4'h0);
        @(posedge clk);
        rd(OFS_ERR_FLAGS, 16'h00b8);
        wr(OFS_ERR_EN, 16'h0008);
        rd(OFS_MAIN_STAT, 16'h0002);
        chk("summary", {15'h0, sum}, 16'h0001);
        fire_ev(4'h3, 4'h0);
        wr(OFS_ERR_FLAGS, 16'h0008);
        rd(OFS_ERR_FLAGS, 16'h00b8);
        wr(OFS_ERR_FLAGS, 16'h00ff);
        rd(OFS_MAIN_STAT, 16'h0000);
        host <= 1'b1;
        repeat (3) @(posedge clk);
        fire_ev(4'h1, 4'h0);
        @(posedge clk);
        rd(OFS_ERR_FLAGS, 16'h0000);
        fire_ev(4'h6, 4'h0);
        wr(OFS_ERR_EN, 16'h0002);
        rd(OFS_ERR_FLAGS, 16'h0002);
        chk("summary", {15'h0, sum}, 16'h0001);
        for (int n = 0; n < 16; n++) begin
            wr(OFS_EP_BASE + n[4:0], 16'hffff);
            rd(OFS_EP_BASE + n[4:0], n == 0 ? 16'h00df : 16'h001f);
        end
        chk("ep0 host bits", {14'h0, ls, nr}, 16'h0003);
        chk("setup", su, 16'h0000);
        host <= 1'b0;
        repeat (4) @(posedge clk);
        rd(OFS_EP_BASE, 16'h001f);
        for (int n = 0; n < 16; n++) begin
            wr(OFS_EP_BASE + n[4:0], {11'h0, n[0], n[3:0]});
            e_rx[n] = n[3];
            e_tx[n] = n[2];
            e_st[n] = n[1];
            e_hs[n] = n[0];
            e_su[n] = n[3] && n[2] && !n[0];
        end
        fire_ev(4'h8, 4'h4);
        repeat (3) @(posedge clk);
        chk("rx", rx, e_rx);
        chk("tx", tx, e_tx);
        chk("setup", su, e_su);
        chk("handshake", hs, e_hs);
        chk("stalled", sl, e_st | 16'h0010);
        rd(OFS_EP_BASE + 5'h04, 16'h0006);
        wr(OFS_PWM_CTRL, 16'h0200);
        rd(OFS_PWM_CTRL, 16'h0200);
        chk("pwm idle", {15'h0, pwm}, 16'h0001);
        wr(OFS_PWM_CTRL, 16'hffff);
        rd(OFS_PWM_CTRL, 16'h8300);
        wr(OFS_PWM_CTRL, 16'h0100);
        c0 = {8'h00, cnt};
        repeat (3) @(posedge clk);
        chk("counter run", {15'h0, c0[7:0] != cnt}, 16'h0001);
        chk("pwm off", {15'h0, pwm}, 16'h0000);
        wr(OFS_PWM_CTRL, 16'h0000);
        repeat (2) @(posedge clk);
        c0 = {8'h00, cnt};
        repeat (3) @(posedge clk);
        chk("counter stop", {8'h00, cnt}, c0);
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule
bind uer_regs uer_chk chk_inst (.CLK_I, .RESET_I, .CE_I, .ADDR_I, .WDATA_I,
    .WR_I, .RD_I, .RDATA_O, .HOST_ROLE_I, .BUFFER_OVERRUN_ERR_I,
    .TOKEN_CRC_FAIL_I, .EP_STALL_SET_I, .EP_STALL_EP_I, .TOKEN_REJECT_O,
    .RX_TRUNCATE_O, .ERROR_SUMMARY_IRQ_FLAG_O, .ENDPOINT_RX_EN_O,
    .ENDPOINT_TX_EN_O, .SETUP_ALLOWED_O, .ENDPOINT_HANDSHAKE_EN_O,
    .ENDPOINT_STALLED_O, .LOW_SPEED_DIRECT_O, .NAK_RETRY_DISABLE_O,
    .VBUS_PWM_O);
